// ==== hw/pcg_consts.svh ====
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH
// Register byte addresses
`define PCG_ADDR_DATA 8'h00
`define PCG_ADDR_DIR 8'h04
`define PCG_ADDR_PULL 8'h08
`define PCG_ADDR_SLEW 8'h0C
`define PCG_ADDR_DRIVE 8'h10
`define PCG_ADDR_GANG 8'h14
// Field positions and widths
`define PCG_WIDTH 8
`define PCG_GANG_EN_BIT 0
`define PCG_MASTER_PIN 0
`define PCG_BYTE_HI 7
// Reset values
`define PCG_RST_BYTE 8'h00
`define PCG_RST_WORD 32'h0000_0000
// Address decode slice
`define PCG_ADDR_HI 7
// Transfer type bit that marks an active transfer
`define PCG_HTRANS_ACTIVE 1
`endif

// ==== hw/pcg_pkg.sv ====
`default_nettype none
package pcg_pkg;
  typedef logic [7:0] pcg_byte_t;
endpackage : pcg_pkg
`default_nettype wire

// ==== hw/pcg_port.sv ====
// Overview of operation
// - A pin whose direction bit is 0 has its driver off and data reads return its sampled level; the code drives group members and reads their latched bits.
// - A pin whose direction bit is 1 is driven and data reads return the latched bit.
// - On an input pin a pull enable of 1 turns the pull-up on and 0 leaves it off.
// - On an output pin the pull enable is ignored and the pull-up stays off.
// - Each slew bit enables slew limiting on its pin when 1, with no effect on inputs.
// - Each drive bit selects high drive when 1 and low when 0, with no effect on inputs.
// - The ganged pin select field in bits 7..1 is write-once and marks group members.
// - With ganging on, group pins take data, drive and slew from port bit 0.
// - A select bit of 1 joins the group only when the ganged enable is 1; 0 excludes.
// - The ganged enable at bit 0 is write-once and turns ganging on when 1.
// - With ganging on, port bit 0 is an output whatever its direction bit says.
// - Every data write latches all eight bits and output pins drive their latched bits.
// - Reset clears data latches and makes all pins undriven inputs with pull-ups off.
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`include "pcg_consts.svh"
`default_nettype none
module pcg_port (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic hreadyout,
  output var logic hresp,
  output var logic [31:0] hrdata,
  input wire logic [7:0] pin_in,
  output var logic [7:0] pin_out,
  output var logic [7:0] pin_oe,
  output var logic [7:0] pin_pullup,
  output var logic [7:0] pin_slew,
  output var logic [7:0] pin_drive
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  pcg_pkg::pcg_byte_t sync1_reg, sync1_next;
  pcg_pkg::pcg_byte_t sync2_reg, sync2_next;

  // Two stages before any logic looks at the pins
  // Pin levels move with no regard to hclk, so only sync2 may feed logic
  // Reading sync1 anywhere else would let a metastable level spread
  always_comb begin
    sync1_next = pin_in;
    sync2_next = sync1_reg;
  end

  // Synchroniser flops, cleared by reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= `PCG_RST_BYTE;
      sync2_reg <= `PCG_RST_BYTE;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture
  logic wr_pend_reg, wr_pend_next;
  logic rd_pend_reg, rd_pend_next;
  logic [`PCG_ADDR_HI:0] addr_reg, addr_next;
  logic take;

  // A transfer is taken when selected, ready and active
  // hsize is not decoded; every transfer is taken as a whole word
  assign take = hsel && hready && htrans[`PCG_HTRANS_ACTIVE];

  // Latch the address phase for the following data phase
  // Only the address phase carries haddr, so it is held for the data phase
  always_comb begin
    wr_pend_next = 1'b0;
    rd_pend_next = 1'b0;
    addr_next = addr_reg;
    if (hready) begin
      wr_pend_next = take && hwrite;
      rd_pend_next = take && !hwrite;
      if (take) begin
        addr_next = haddr[`PCG_ADDR_HI:0];
      end
    end
  end

  // Pending transfer flags and held address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= '0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg <= addr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  pcg_pkg::pcg_byte_t data_latch_reg, data_latch_next;
  pcg_pkg::pcg_byte_t dir_reg, dir_next;
  pcg_pkg::pcg_byte_t pull_reg, pull_next;
  pcg_pkg::pcg_byte_t slew_reg, slew_next;
  pcg_pkg::pcg_byte_t drive_reg, drive_next;
  pcg_pkg::pcg_byte_t gang_reg, gang_next;
  logic gang_locked_reg, gang_locked_next;

  // Register writes in the data phase
  always_comb begin
    data_latch_next = data_latch_reg;
    dir_next = dir_reg;
    pull_next = pull_reg;
    slew_next = slew_reg;
    drive_next = drive_reg;
    gang_next = gang_reg;
    gang_locked_next = gang_locked_reg;
    // Unmapped addresses fall through and change nothing
    if (wr_pend_reg) begin
      if (addr_reg == `PCG_ADDR_DATA) begin
        data_latch_next = hwdata[`PCG_BYTE_HI:0];
      end else if (addr_reg == `PCG_ADDR_DIR) begin
        dir_next = hwdata[`PCG_BYTE_HI:0];
      end else if (addr_reg == `PCG_ADDR_PULL) begin
        pull_next = hwdata[`PCG_BYTE_HI:0];
      end else if (addr_reg == `PCG_ADDR_SLEW) begin
        slew_next = hwdata[`PCG_BYTE_HI:0];
      end else if (addr_reg == `PCG_ADDR_DRIVE) begin
        drive_next = hwdata[`PCG_BYTE_HI:0];
      end else if (addr_reg == `PCG_ADDR_GANG) begin
        // The lock sets on any gang write, zero included; only reset clears it
        if (!gang_locked_reg) begin
          gang_next = hwdata[`PCG_BYTE_HI:0];
          gang_locked_next = 1'b1;
        end
      end
    end
  end

  // Reset leaves data zero and every pin an undriven input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_latch_reg <= `PCG_RST_BYTE;
      dir_reg <= `PCG_RST_BYTE;
      pull_reg <= `PCG_RST_BYTE;
      slew_reg <= `PCG_RST_BYTE;
      drive_reg <= `PCG_RST_BYTE;
      gang_reg <= `PCG_RST_BYTE;
      gang_locked_reg <= 1'b0;
    end else begin
      data_latch_reg <= data_latch_next;
      dir_reg <= dir_next;
      pull_reg <= pull_next;
      slew_reg <= slew_next;
      drive_reg <= drive_next;
      gang_reg <= gang_next;
      gang_locked_reg <= gang_locked_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective per-pin settings
  logic gang_on;
  pcg_pkg::pcg_byte_t eff_dir, eff_data, eff_slew, eff_drive, in_pin;

  assign gang_on = gang_reg[`PCG_GANG_EN_BIT];

  // Per-pin group membership and effective settings
  // Members are forced to drive so that a ganged group never floats
  genvar gi;
  generate
    for (gi = 0; gi < `PCG_WIDTH; gi++) begin : g_pin
      logic member;
      // The master pin is never a member; ganging only forces its direction
      if (gi == `PCG_MASTER_PIN) begin : g_master
        assign member = 1'b0;
        assign eff_dir[gi] = dir_reg[gi] | gang_on;
      end else begin : g_other
        assign member = gang_on & gang_reg[gi];
        assign eff_dir[gi] = dir_reg[gi] | member;
      end
      // Group members copy data, drive and slew of the master pin
      assign eff_data[gi] = member ? data_latch_reg[`PCG_MASTER_PIN] : data_latch_reg[gi];
      assign eff_drive[gi] = member ? drive_reg[`PCG_MASTER_PIN] : drive_reg[gi];
      assign eff_slew[gi] = member ? slew_reg[`PCG_MASTER_PIN] : slew_reg[gi];
      assign in_pin[gi] = ~eff_dir[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs
  pcg_pkg::pcg_byte_t out_reg, out_next;
  pcg_pkg::pcg_byte_t oe_reg, oe_next;
  pcg_pkg::pcg_byte_t pu_reg, pu_next;
  pcg_pkg::pcg_byte_t sl_reg, sl_next;
  pcg_pkg::pcg_byte_t ds_reg, ds_next;

  // Drive and pad controls from the effective settings
  always_comb begin
    oe_next = eff_dir;
    out_next = eff_data;
    pu_next = pull_reg & in_pin;
    // Slew and drive are masked on inputs, where they have no effect
    sl_next = eff_slew & eff_dir;
    ds_next = eff_drive & eff_dir;
  end

  // Pad controls are registered so they all change on one edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_reg <= `PCG_RST_BYTE;
      oe_reg <= `PCG_RST_BYTE;
      pu_reg <= `PCG_RST_BYTE;
      sl_reg <= `PCG_RST_BYTE;
      ds_reg <= `PCG_RST_BYTE;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
      pu_reg <= pu_next;
      sl_reg <= sl_next;
      ds_reg <= ds_next;
    end
  end

  // Ports come straight from the output flops
  assign pin_out = out_reg;
  assign pin_oe = oe_reg;
  assign pin_pullup = pu_reg;
  assign pin_slew = sl_reg;
  assign pin_drive = ds_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered in the address phase so it stands in the data phase
  logic [31:0] rdata_reg, rdata_next;
  pcg_pkg::pcg_byte_t data_view;
  logic [`PCG_ADDR_HI:0] ra;

  // Outputs read their latch, inputs their synchronised level
  assign data_view = (eff_dir & data_latch_reg) | (in_pin & sync2_reg);
  assign ra = haddr[`PCG_ADDR_HI:0];

  // A read right after a write to the same register sees the old value
  // Unmapped addresses read zero; bits above the byte read zero
  always_comb begin
    rdata_next = `PCG_RST_WORD;
    if (take && !hwrite) begin
      if (ra == `PCG_ADDR_DATA) begin
        rdata_next[`PCG_BYTE_HI:0] = data_view;
      end else if (ra == `PCG_ADDR_DIR) begin
        rdata_next[`PCG_BYTE_HI:0] = dir_reg;
      end else if (ra == `PCG_ADDR_PULL) begin
        rdata_next[`PCG_BYTE_HI:0] = pull_reg;
      end else if (ra == `PCG_ADDR_SLEW) begin
        rdata_next[`PCG_BYTE_HI:0] = slew_reg;
      end else if (ra == `PCG_ADDR_DRIVE) begin
        rdata_next[`PCG_BYTE_HI:0] = drive_reg;
      end else if (ra == `PCG_ADDR_GANG) begin
        rdata_next[`PCG_BYTE_HI:0] = gang_reg;
      end
    end
  end

  // Read data register, zero outside a read data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= `PCG_RST_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Zero wait states, always OKAY
  logic rdy_reg, rdy_next;
  logic resp_reg, resp_next;

  // The slave never stalls and never reports an error
  always_comb begin
    rdy_next = 1'b1;
    resp_next = 1'b0;
  end

  // Ready stays high from reset onward
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy_reg <= 1'b1;
      resp_reg <= 1'b0;
    end else begin
      rdy_reg <= rdy_next;
      resp_reg <= resp_next;
    end
  end

  // Bus outputs straight from their flops
  assign hreadyout = rdy_reg;
  assign hresp = resp_reg;
  assign hrdata = rdata_reg;

endmodule : pcg_port
`default_nettype wire

// ==== verif/pcg_pins_model.sv ====
`default_nettype none
module pcg_pins_model (
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output var logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] flt = 8'h00;
  // Floating pins wander every cycle
  always @(posedge clk) flt <= ~pin_in;
  // Wire level: port driver, then board, then pull-up, else floating
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | flt));
endmodule : pcg_pins_model
`default_nettype wire

// ==== verif/pcg_port_chk.sv ====
`default_nettype none
module pcg_port_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] pin_slew,
  input wire logic [7:0] pin_drive
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Transfer taken this edge
  wire tk = hsel && hready && htrans[1];
  a_slew_gated: assert property ((pin_slew & ~pin_oe) == 8'h00)
    else $error("slew on input");
  a_drive_gated: assert property ((pin_drive & ~pin_oe) == 8'h00)
    else $error("drive on input");
  a_pull_output: assert property ((pin_pullup & pin_oe) == 8'h00)
    else $error("pull-up on output");
  a_reset_quiet: assert property ($rose(hresetn) |-> !pin_oe && !pin_pullup)
    else $error("pins active after reset");
  a_oe_by_write: assert property ($changed(pin_oe) |-> $past(tk && hwrite, 3))
    else $error("direction moved without write");
  a_pull_by_write: assert property ($changed(pin_pullup) |-> $past(tk && hwrite, 3))
    else $error("pull-up moved without write");
  a_out_by_write: assert property ($changed(pin_out) |-> $past(tk && hwrite, 3))
    else $error("output moved without write");
  a_rd_idle: assert property (!(tk && !hwrite) |=> hrdata == 32'h0)
    else $error("read data outside read");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
endmodule : pcg_port_chk
bind pcg_port pcg_port_chk pcg_port_chk_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hresp(hresp), .hrdata(hrdata),
  .pin_out(pin_out),
  .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_slew(pin_slew), .pin_drive(pin_drive));
`default_nettype wire

// ==== verif/port_c_gpio_ganged_drive_tb_top.sv ====
`default_nettype none
module port_c_gpio_ganged_drive_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, gw;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [7:0] ext_en = 8'h00, ext_val = 8'h00, a, v, pin_in, pin_out, pin_oe;
  logic [7:0] pin_pullup, pin_slew, pin_drive, mdl [0:6];
  wire hready, hresp;
  int n_mismatch = 0, n_checks = 0;
  initial forever #10 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////
  pcg_port pcg_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_slew(pin_slew), .pin_drive(pin_drive));
  pcg_pins_model pcg_pins_model_inst (.clk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task end_of_test(input int e);
    n_mismatch += e;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for hready at a rising edge
  task wt;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 99);
    if (n >= 99) end_of_test(1);
  endtask : wt
  // One single AHB transfer, address phase then data phase
  task xfer(input logic w, input logic [7:0] ad, input logic [7:0] wd);
    haddr <= {24'h0, ad};
    hwrite <= w;
    htrans <= 2'h2;
    wt();
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wt();
    r = hrdata;
  endtask : xfer
  // Group members copy bit 0
  function logic [7:0] fol(input logic [7:0] x, input logic [7:0] m);
    return x & ~m | {8{x[0]}} & m;
  endfunction : fol
  // Compare every pin output and the data read with the model
  task cmp;
    logic [7:0] m, ed, k;
    m = mdl[5][0] ? mdl[5] & 8'hFE : 8'h00;
    ed = mdl[1] | m | {7'h0, mdl[5][0]};
    k = ed | ext_en | mdl[2];
    chk(pin_oe, ed);
    chk(pin_out & ed, fol(mdl[0], m) & ed);
    chk(pin_slew, fol(mdl[3], m) & ed);
    chk(pin_drive, fol(mdl[4], m) & ed);
    chk(pin_pullup, mdl[2] & ~ed);
    xfer(1'b0, 8'h00, 8'h00);
    chk(r & k, (mdl[0] & ed | ext_val & ext_en & ~ed | mdl[2] & ~ext_en & ~ed) & k);
  endtask : cmp
  ////////////////////////////////////////////////////////////////////////
  // Two reset passes: ganging left off, then ganging on
  initial begin
    void'($urandom(322));
    for (int p = 0; p < 2; p++) begin
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk); // Let the pin synchroniser refill
      mdl = '{default: 8'h00};
      gw = 1'b0;
      cmp();
      for (int i = 0; i < 12; i++) begin
        ext_en <= 8'($urandom);
        ext_val <= 8'($urandom);
        a = (i == 6 || i == 8) ? 8'h14 : i == 9 ? 8'h18 : 8'(4 * ($urandom % 5));
        v = 8'($urandom);
        if (i == 6) v = v & 8'hFE | 8'(p);
        if (a < 8'h18 && (a != 8'h14 || !gw)) mdl[a[4:2]] = v;
        gw = gw | (a == 8'h14);
        xfer(1'b1, a, v);
        repeat (4) @(posedge hclk);
        cmp();
      end
      for (int i = 1; i < 7; i++) begin
        xfer(1'b0, 8'(4 * i), 8'h00);
        chk(r, {24'h0, mdl[i]});
      end
    end
    end_of_test(0);
  end
endmodule : port_c_gpio_ganged_drive_tb_top
`default_nettype wire
